//--- design/eta_pkg.sv
// Package: constants and types of the transmit-abort status block
package eta_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ETA_OFS_TX_STATUS = 8'h00;
    localparam logic [7:0] ETA_OFS_EVT_STAT  = 8'h04;
    localparam logic [7:0] ETA_OFS_EVT_MASK  = 8'h08;
    localparam logic [7:0] ETA_OFS_CONFIG    = 8'h0c;

    // ------------------------------------------------------------
    // Transmit status word field positions
    // ------------------------------------------------------------
    localparam int ETA_TS_OK       = 15;
    localparam int ETA_TS_UNDERRUN = 9;
    localparam int ETA_TS_OVERSIZE = 8;
    localparam int ETA_TS_UNUSED   = 7;

    // ------------------------------------------------------------
    // Event status / mask field positions
    // ------------------------------------------------------------
    localparam int ETA_EV_DONE     = 0;
    localparam int ETA_EV_UNDERRUN = 1;
    localparam int ETA_EV_OVERSIZE = 2;
    localparam int ETA_EV_W        = 3;

    // ------------------------------------------------------------
    // Configuration field positions
    // ------------------------------------------------------------
    localparam int ETA_CF_HUGE = 0;
    localparam int ETA_CF_DMA  = 1;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [31:0]         ETA_TS_RESET   = 32'h0000_0000;
    localparam logic [ETA_EV_W-1:0] ETA_EV_RESET   = 3'h0;
    localparam logic [1:0]          ETA_CF_RESET   = 2'h0;
    localparam int                  ETA_MAX_FRAME  = 1518;
    localparam int                  ETA_CNT_W      = 12;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_FLUSH
    } eta_state_type;

    // Signals from the transmit datapath and FIFO
    typedef struct packed {
        logic frame_start;     // First byte of a frame about to leave
        logic byte_take;       // Medium takes one byte this cycle
        logic frame_end;       // Last byte left normally
        logic fifo_empty;      // FIFO holds no data
        logic fifo_last_in;    // Last word of the frame is in the FIFO
        logic fifo_below_half; // FIFO at or below half full
        logic flush_done;      // FIFO finished discarding
    } eta_tx_side_type;

endpackage

//--- design/eta_tx_abort.sv
// Module: transmit-abort status logic for FIFO underrun and oversize frames
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Summary of operation
// - A byte request from the medium while the FIFO is dry mid-frame aborts and sets bit 9.
// - After an underrun abort the rest of the frame is flushed from the FIFO by hardware.
// - The buffer-done flag is set whenever the underrun bit becomes set.
// - A frame past 1518 bytes aborts unless huge frames are allowed, setting bit 8, or bit 9 if byte 1519 also underruns.
// - After an oversize abort the frame is flushed from the FIFO by hardware.
// - The buffer-done flag is set whenever the oversize bit becomes set.
// - Holding-empty and FIFO-half flags rise only once the flush is over.
// - Bit 7 of the transmit status word always reads zero.
// - The status word loads at frame end or abort, setting buffer-done at that moment.
// - In DMA mode the low 16 status bits are written to the descriptor status slot.
// ----------------------------------------------------------------
module eta_tx_abort (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    input  wire eta_pkg::eta_tx_side_type tx_side,
    output logic                          fifo_flush,
    output logic                          tx_abort,
    output logic                          tx_holding_empty_flag,
    output logic                          tx_fifo_half_flag,
    output logic                          tx_buffer_done,
    output logic [15:0]                   descriptor_status_slot,
    output logic                          descriptor_status_wr,
    output logic                          irq
);
    import eta_pkg::*;

    eta_state_type          state_reg;
    eta_state_type          state_next;
    logic [ETA_CNT_W-1:0]   count_reg;
    logic [31:0]            status_reg;
    logic [ETA_EV_W-1:0]    evt_reg;
    logic [ETA_EV_W-1:0]    mask_reg;
    logic [1:0]             cfg_reg;
    logic                   underrun_hit;
    logic                   oversize_hit;
    logic                   good_end;
    logic                   complete;
    logic [31:0]            status_new;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // True when a strobe addresses the given register offset
    function automatic logic addr_hit(input logic       strobe,
                                      input logic [7:0] addr,
                                      input logic [7:0] ofs);
        return strobe && (addr == ofs);
    endfunction

    // ------------------------------------------------------------
    // Abort detection
    // ------------------------------------------------------------
    // Medium asks for data the feeder has not delivered yet
    assign underrun_hit = (state_reg == ST_SEND) && tx_side.byte_take
                          && tx_side.fifo_empty && !tx_side.fifo_last_in;
    // The byte being taken would be number 1519 or beyond
    assign oversize_hit = (state_reg == ST_SEND) && tx_side.byte_take
                          && (count_reg >= ETA_CNT_W'(ETA_MAX_FRAME))
                          && !cfg_reg[ETA_CF_HUGE] && !underrun_hit;
    assign good_end     = (state_reg == ST_SEND) && tx_side.frame_end
                          && !underrun_hit && !oversize_hit;
    assign tx_abort     = underrun_hit || oversize_hit;
    assign complete     = tx_abort || good_end;

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    // Next state: aborts go through a flush before the FIFO is ready
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (tx_side.frame_start) begin
                    state_next = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_abort) begin
                    state_next = ST_FLUSH;
                end else if (good_end) begin
                    state_next = ST_IDLE;
                end
            end
            ST_FLUSH: begin
                if (tx_side.flush_done) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Byte counter of the frame in flight, saturating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (state_reg == ST_IDLE) begin
            count_reg <= '0;
        end else if (tx_side.byte_take && (count_reg != '1)) begin
            count_reg <= count_reg + ETA_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // FIFO side outputs
    // ------------------------------------------------------------
    // Flush runs until the FIFO reports it empty of the frame
    assign fifo_flush            = (state_reg == ST_FLUSH);
    // Ready flags held low during the flush
    assign tx_holding_empty_flag = (state_reg != ST_FLUSH) && tx_side.fifo_empty;
    assign tx_fifo_half_flag     = (state_reg != ST_FLUSH) && tx_side.fifo_below_half;

    // ------------------------------------------------------------
    // Transmit status word and descriptor copy
    // ------------------------------------------------------------
    // Outcome of the frame ending now; bit 7 and all other bits stay zero
    always_comb begin
        status_new                  = '0;
        status_new[ETA_TS_OK]       = good_end;
        status_new[ETA_TS_UNDERRUN] = underrun_hit;
        status_new[ETA_TS_OVERSIZE] = oversize_hit;
    end

    // Whole word is rewritten at every completion, so no abort bit goes stale
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= ETA_TS_RESET;
        end else if (complete) begin
            status_reg <= status_new;
        end
    end

    // Descriptor status slot written in DMA mode with the new word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            descriptor_status_slot <= '0;
            descriptor_status_wr   <= 1'b0;
        end else begin
            descriptor_status_wr <= complete && cfg_reg[ETA_CF_DMA];
            if (complete && cfg_reg[ETA_CF_DMA]) begin
                descriptor_status_slot <= status_new[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Event status, mask, configuration and interrupt
    // ------------------------------------------------------------
    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_reg <= ETA_EV_RESET;
        end else begin
            evt_reg <= (evt_reg & ~(addr_hit(reg_wr, reg_addr, ETA_OFS_EVT_STAT)
                                    ? reg_wdata[ETA_EV_W-1:0] : ETA_EV_RESET))
                       | {oversize_hit, underrun_hit, complete};
        end
    end

    // Software-written mask and configuration
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= ETA_EV_RESET;
            cfg_reg  <= ETA_CF_RESET;
        end else begin
            if (addr_hit(reg_wr, reg_addr, ETA_OFS_EVT_MASK)) begin
                mask_reg <= reg_wdata[ETA_EV_W-1:0];
            end
            if (addr_hit(reg_wr, reg_addr, ETA_OFS_CONFIG)) begin
                cfg_reg <= reg_wdata[1:0];
            end
        end
    end

    assign tx_buffer_done = evt_reg[ETA_EV_DONE];
    assign irq            = |(evt_reg & mask_reg);

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ETA_OFS_TX_STATUS: reg_rdata <= status_reg;
                ETA_OFS_EVT_STAT:  reg_rdata <= {29'h0, evt_reg};
                ETA_OFS_EVT_MASK:  reg_rdata <= {29'h0, mask_reg};
                ETA_OFS_CONFIG:    reg_rdata <= {30'h0, cfg_reg};
                default:           reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Underrun abort
    // ------------------------------------------------------------
    chk_underrun_sets_bit: assert property (underrun_hit |=> status_reg[ETA_TS_UNDERRUN]
        && !status_reg[ETA_TS_OK])
        else $error("underrun did not set its status bit");
    chk_underrun_flush_run: assert property (underrun_hit |=> fifo_flush
        && state_reg == ST_FLUSH)
        else $error("underrun did not start a flush");
    chk_underrun_done_flag: assert property ($rose(status_reg[ETA_TS_UNDERRUN])
        |-> tx_buffer_done)
        else $error("underrun bit set without buffer done");
    chk_abort_one_pulse: assert property (tx_abort |=> !tx_abort)
        else $error("abort pulse lasted more than one cycle");

    // ------------------------------------------------------------
    // Oversize abort
    // ------------------------------------------------------------
    chk_oversize_sets_bit: assert property ((state_reg == ST_SEND && tx_side.byte_take
        && count_reg == ETA_CNT_W'(ETA_MAX_FRAME) && !cfg_reg[ETA_CF_HUGE] && !underrun_hit)
        |=> status_reg[ETA_TS_OVERSIZE] && fifo_flush)
        else $error("frame past limit not aborted");
    chk_oversize_flush_hold: assert property (oversize_hit ##1 !tx_side.flush_done
        |=> fifo_flush)
        else $error("oversize flush ended early");
    chk_oversize_done_flag: assert property (oversize_hit |=> tx_buffer_done
        && evt_reg[ETA_EV_OVERSIZE])
        else $error("oversize abort without buffer done");
    chk_huge_no_oversize: assert property (cfg_reg[ETA_CF_HUGE] |-> !oversize_hit)
        else $error("oversize abort while huge frames allowed");

    // ------------------------------------------------------------
    // Flush and ready flags
    // ------------------------------------------------------------
    chk_flags_after_flush: assert property (fifo_flush |-> !tx_holding_empty_flag
        && !tx_fifo_half_flag)
        else $error("ready flags raised during flush");
    chk_flush_release: assert property (fifo_flush && tx_side.flush_done
        |=> !fifo_flush && state_reg == ST_IDLE)
        else $error("flush did not end on its completion");
    chk_flags_follow_fifo: assert property (!fifo_flush
        |-> tx_holding_empty_flag == tx_side.fifo_empty
        && tx_fifo_half_flag == tx_side.fifo_below_half)
        else $error("ready flags differ from the FIFO levels");

    // ------------------------------------------------------------
    // Status word and descriptor
    // ------------------------------------------------------------
    chk_unused_bit_zero: assert property (reg_rd && reg_addr == ETA_OFS_TX_STATUS
        |=> !reg_rdata[ETA_TS_UNUSED])
        else $error("unused status bit read as one");
    chk_unused_bit_held: assert property (!status_reg[ETA_TS_UNUSED])
        else $error("unused status bit set");
    chk_status_on_end: assert property (good_end |=> status_reg[ETA_TS_OK]
        && tx_buffer_done && state_reg == ST_IDLE)
        else $error("good frame end not recorded");
    chk_status_held: assert property (!complete |=> $stable(status_reg))
        else $error("status word changed without a completion");
    chk_descriptor_copy: assert property (descriptor_status_wr
        |-> descriptor_status_slot == status_reg[15:0] && $past(cfg_reg[ETA_CF_DMA]))
        else $error("descriptor slot differs from status word");
    chk_descriptor_when: assert property (descriptor_status_wr |-> $past(complete))
        else $error("descriptor written without a completion");
    chk_abort_bits_fresh: assert property (good_end |=> !status_reg[ETA_TS_UNDERRUN]
        && !status_reg[ETA_TS_OVERSIZE])
        else $error("stale abort bit after good frame");

    // ------------------------------------------------------------
    // Event status and register port
    // ------------------------------------------------------------
    chk_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data present without a read");
    chk_done_sticky: assert property (tx_buffer_done
        && !addr_hit(reg_wr, reg_addr, ETA_OFS_EVT_STAT) |=> tx_buffer_done)
        else $error("buffer done dropped without a clear");
    chk_done_clear: assert property (addr_hit(reg_wr, reg_addr, ETA_OFS_EVT_STAT)
        && reg_wdata[ETA_EV_DONE] && !complete |=> !tx_buffer_done)
        else $error("buffer done survived a write-one clear");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    cov_underrun_abort: cover property (underrun_hit ##[1:20] state_reg == ST_IDLE);
    cov_oversize_abort: cover property (oversize_hit ##[1:20] state_reg == ST_IDLE);
    cov_good_frame:     cover property (good_end ##1 state_reg == ST_IDLE);
    cov_both_causes:    cover property (underrun_hit && count_reg >= ETA_CNT_W'(ETA_MAX_FRAME));
    cov_irq_raised:     cover property ($rose(irq));

endmodule

//--- verif/eta_feed_model.sv
// Behavioural feeder standing in for the DMA side and transmit FIFO of the abort block
`timescale 1ns/10ps
module eta_feed_model #(
    parameter int FLUSH_LAT = 4
) (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            tx_abort,
    input  wire logic            fifo_flush,
    output eta_pkg::eta_tx_side_type tx_side
);
    import eta_pkg::*;

    // ------------------------------------------------------------
    // Feed state
    // ------------------------------------------------------------
    localparam eta_tx_side_type IDLE_V = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    eta_tx_side_type feed = IDLE_V;
    logic [3:0]      fl_cnt;
    logic            fl_done;

    // Flush completion is merged into the side bundle
    always_comb begin
        tx_side            = feed;
        tx_side.flush_done = fl_done;
    end

    // FIFO discard takes a fixed few cycles, then reports once
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fl_cnt  <= 4'h0;
            fl_done <= 1'b0;
        end else begin
            fl_done <= 1'b0;
            if (fifo_flush && !fl_done) begin
                fl_cnt <= fl_cnt + 4'h1;
                if (fl_cnt == FLUSH_LAT - 1) begin
                    fl_done <= 1'b1;
                    fl_cnt  <= 4'h0;
                end
            end
        end
    end

    // One byte per cycle; at byte dry the FIFO is empty before the last word is in
    task automatic send_frame(input int n, input int dry);
        @(posedge clk);
        feed <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        for (int i = 1; i <= n + 1; i++) begin
            @(posedge clk);
            if (tx_abort || i > n) begin
                break;
            end
            feed.frame_start  <= 1'b0;
            feed.byte_take    <= 1'b1;
            feed.fifo_empty   <= (i == dry) || (i == n);
            feed.fifo_last_in <= (i == n) && (i != dry);
            feed.frame_end    <= (i == n);
        end
        feed <= IDLE_V;
    endtask
endmodule

//--- verif/eta_tx_abort_tb_top.sv
// Testbench for the transmit-abort status block
`timescale 1ns/10ps
module eta_tx_abort_tb_top;
    import eta_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic            clk = 1'b0;
    logic            rstn = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [31:0]     reg_wdata = 32'h0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [31:0]     reg_rdata;
    eta_tx_side_type tx_side;
    logic            fifo_flush, tx_abort, tx_holding_empty_flag, tx_fifo_half_flag;
    logic            tx_buffer_done, descriptor_status_wr, irq;
    logic [15:0]     descriptor_status_slot;
    logic [15:0]     desc_val = 16'h0;
    int              desc_cnt = 0;
    int              failures = 0;
    int              cmp_count = 0;
    int              abort_cnt = 0;
    logic [31:0]     rd;

    always #5 clk = ~clk;

    eta_tx_abort eta_tx_abort_inst (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_side(tx_side),
        .fifo_flush(fifo_flush), .tx_abort(tx_abort),
        .tx_holding_empty_flag(tx_holding_empty_flag), .tx_fifo_half_flag(tx_fifo_half_flag),
        .tx_buffer_done(tx_buffer_done), .descriptor_status_slot(descriptor_status_slot),
        .descriptor_status_wr(descriptor_status_wr), .irq(irq)
    );

    eta_feed_model eta_feed_model_inst (
        .clk(clk), .rstn(rstn), .tx_abort(tx_abort), .fifo_flush(fifo_flush),
        .tx_side(tx_side)
    );

    // Records every descriptor write and every abort pulse
    always @(posedge clk) begin
        if (descriptor_status_wr === 1'b1) begin
            desc_cnt <= desc_cnt + 1;
            desc_val <= descriptor_status_slot;
        end
        if (tx_abort === 1'b1) begin
            abort_cnt <= abort_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic read_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        reg_read(a, rd);
        chk(name, exp, rd);
    endtask

    // Flush must be running with both ready flags held low, then release them
    task automatic after_abort();
        #1;
        chk("flush", 32'h1, {31'h0, fifo_flush});
        chk("abort_gone", 32'h0, {31'h0, tx_abort});
        chk("empty_flag", 32'h0, {31'h0, tx_holding_empty_flag});
        chk("half_flag", 32'h0, {31'h0, tx_fifo_half_flag});
        chk("done", 32'h1, {31'h0, tx_buffer_done});
        repeat (30) begin
            if (fifo_flush === 1'b0) break;
            @(posedge clk);
            #1;
        end
        chk("flags", 32'h3, {30'h0, tx_holding_empty_flag, tx_fifo_half_flag});
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) read_chk("reset_reg", 8'(i * 4), 32'h0);
        reg_write(ETA_OFS_TX_STATUS, 32'hffff_ffff);
        read_chk("ro_status", ETA_OFS_TX_STATUS, 32'h0);
        reg_write(ETA_OFS_CONFIG, 32'h2);
        eta_feed_model_inst.send_frame(ETA_MAX_FRAME, 0);
        read_chk("max_ok", ETA_OFS_TX_STATUS, 32'h8000);
        chk("done_ok", 32'h1, {31'h0, tx_buffer_done});
        chk("desc_ok", 32'h8000, {desc_cnt[15:0], desc_val} - 32'h1_0000);
        reg_write(ETA_OFS_EVT_STAT, 32'h7);
        chk("done_clr", 32'h0, {31'h0, tx_buffer_done});
        reg_write(ETA_OFS_EVT_MASK, 32'h2);
        eta_feed_model_inst.send_frame(100, 40);
        after_abort();
        chk("irq_on", 32'h1, {31'h0, irq});
        read_chk("underrun", ETA_OFS_TX_STATUS, 32'h0200);
        read_chk("evt_ur", ETA_OFS_EVT_STAT, 32'h3);
        chk("desc_ur", 32'h0200, {16'h0, desc_val});
        reg_write(ETA_OFS_EVT_STAT, 32'h7);
        chk("irq_off", 32'h0, {31'h0, irq});
        eta_feed_model_inst.send_frame(ETA_MAX_FRAME + 1, 0);
        after_abort();
        chk("irq_mask", 32'h0, {31'h0, irq});
        read_chk("oversize", ETA_OFS_TX_STATUS, 32'h0100);
        read_chk("evt_os", ETA_OFS_EVT_STAT, 32'h5);
        reg_write(ETA_OFS_EVT_STAT, 32'h7);
        eta_feed_model_inst.send_frame(ETA_MAX_FRAME + 1, ETA_MAX_FRAME + 1);
        after_abort();
        read_chk("both", ETA_OFS_TX_STATUS, 32'h0200);
        reg_write(ETA_OFS_CONFIG, 32'h3);
        eta_feed_model_inst.send_frame(ETA_MAX_FRAME + 1, 0);
        read_chk("huge_ok", ETA_OFS_TX_STATUS, 32'h8000);
        chk("desc_n", 32'h5, desc_cnt);
        chk("abort_n", 32'h3, abort_cnt);
        report_and_stop();
    end

    // Cuts a hang short well past the expected run of about 6200 cycles
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
